// ==== rtl/hlb_device.sv ====
// Overview of operation
// - all selects low, memory select high: host
// - host boot: reset as slave, await download
// - idle with pc at vector plus four
// - preset index and count, no external regs
// - control: enable, instruction type, 16-48, lsw
// - host packing must match control packing field
// - host rewrites control and config for repacking
// - host starts by asserting bus request
// - writes accepted only after grant and ack
// - host writes words one at a time, spaced
// - after 256 instructions stop, run kernel
// - lock bit shuts host out until cleared
// - kernel control value loads words singly
// - first vector word must be a nop
// - packing field zero passes words unpacked
// - wait states never slow host downloads
// - external low, link and memory high: link
// - link nibbles packed into 48-bit instructions
// - link data captured on falling link clock
// - most significant nibble first, ack ignorable
// - link boot: buffer takes 48-bit, dma off
// - no boot: external fetch, default registers
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
module hlb_device #(
    parameter logic [23:0] RESET_PC = hlb_pkg::HOST_PC_INIT,
    parameter logic [23:0] NOBOOT_PC = hlb_pkg::NOBOOT_PC_INIT,
    parameter logic [19:0] INDEX_BASE = hlb_pkg::INDEX_INIT
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pins toward the boot source
    hlb_if.device pins,
    // boot kernel side
    input wire logic kernel_dmac_wr,
    input wire logic [15:0] kernel_dmac_data,
    input wire logic bus_lock_bit,
    // state toward the core
    output hlb_pkg::hlb_mode_e boot_mode,
    output logic mode_valid,
    output logic core_run,
    output logic kernel_running,
    output logic [23:0] pc,
    output logic [15:0] dma_channel_control,
    output logic [15:0] system_config_register,
    output logic [19:0] dma_internal_index,
    output logic [15:0] dma_word_count,
    output logic link_buffer_48bit,
    output logic [47:0] instr,
    output logic instr_valid
);

    typedef enum logic [2:0] {
        ST_SETTLE,
        ST_LOADING,
        ST_KERNEL,
        ST_NOBOOT,
        ST_IDLE
    } hlb_phase_e;

    localparam int SYNC_W = 29;
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 29'h3800000; // request and strobes idle high

    logic [SYNC_W-1:0] in_s1;
    logic [SYNC_W-1:0] in_s2;
    logic s_ext, s_lnk, s_bms, s_hbr_n, s_cs_n, s_wr_n, s_lclk;
    logic [1:0] s_addr;
    logic [15:0] s_data;
    logic [3:0] s_ldata;
    logic wr_prev;
    logic lclk_prev;
    logic [1:0] settle;
    hlb_phase_e phase;
    logic granted;
    logic [47:0] pack_reg;
    logic [3:0] pack_cnt;
    logic wr_done, host_wr_ok, word_in, nib_in, host_fire, link_fire, fire;
    logic [1:0] packing_mode_field;
    hlb_pkg::hlb_mode_e strap_mode;

    // every pin passes two flops; only in_s2 is read by logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_s1 <= SYNC_IDLE;
            in_s2 <= SYNC_IDLE;
        end else begin
            in_s1 <= {pins.external_boot_select, pins.link_boot_select,
                      pins.boot_memory_select, pins.host_bus_request_n,
                      pins.host_chip_select_n, pins.host_write_n, pins.host_addr,
                      pins.host_data, pins.link_clk, pins.link_data};
            in_s2 <= in_s1;
        end
    end

    assign {s_ext, s_lnk, s_bms, s_hbr_n, s_cs_n, s_wr_n, s_addr, s_data,
            s_lclk, s_ldata} = in_s2;

    // edge history for host strobe and link clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_prev <= 1'b1;
            lclk_prev <= 1'b0;
        end else begin
            wr_prev <= s_wr_n;
            lclk_prev <= s_lclk;
        end
    end

    // strap decode; other combos fall to unbuilt prom boot
    always_comb begin
        if (!s_ext && !s_lnk && s_bms) begin
            strap_mode = hlb_pkg::HLB_MODE_HOST;
        end else if (!s_ext && s_lnk && s_bms) begin
            strap_mode = hlb_pkg::HLB_MODE_LINK;
        end else if (!s_ext && !s_lnk && !s_bms) begin
            strap_mode = hlb_pkg::HLB_MODE_NOBOOT;
        end else begin
            strap_mode = hlb_pkg::HLB_MODE_PROM;
        end
    end

    // strobe end takes the word, data stable by then
    assign wr_done = !wr_prev && s_wr_n;
    assign host_wr_ok = wr_done && granted && !bus_lock_bit
                        && boot_mode == hlb_pkg::HLB_MODE_HOST;
    assign packing_mode_field = dma_channel_control[hlb_pkg::PACKING_MODE_FIELD_LSB +: 2];
    assign word_in = host_wr_ok && s_addr == hlb_pkg::ADDR_BUFFER0
                     && dma_channel_control[hlb_pkg::DMAC_ENABLE_BIT]
                     && (phase == ST_LOADING || phase == ST_KERNEL);
    assign nib_in = lclk_prev && !s_lclk && phase == ST_LOADING
                    && boot_mode == hlb_pkg::HLB_MODE_LINK;
    assign host_fire = word_in && (packing_mode_field == hlb_pkg::PACKING_MODE_FIELD_NONE
                                   || pack_cnt == hlb_pkg::LAST_WORD);
    assign link_fire = nib_in && pack_cnt == hlb_pkg::LAST_NIBBLE;
    assign fire = host_fire || link_fire;

    // boot phase; mode is caught once, a few cycles after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= ST_SETTLE;
            settle <= 2'h0;
            boot_mode <= hlb_pkg::HLB_MODE_HOST;
            mode_valid <= 1'b0;
            core_run <= 1'b0;
            kernel_running <= 1'b0;
            pc <= RESET_PC;
        end else begin
            case (phase)
                ST_SETTLE: begin
                    settle <= settle + 2'h1;
                    if (settle == hlb_pkg::STRAP_SETTLE) begin
                        boot_mode <= strap_mode;
                        mode_valid <= 1'b1;
                        case (strap_mode)
                            hlb_pkg::HLB_MODE_HOST, hlb_pkg::HLB_MODE_LINK: begin
                                phase <= ST_LOADING;
                                pc <= RESET_PC;
                            end
                            hlb_pkg::HLB_MODE_NOBOOT: begin
                                phase <= ST_NOBOOT;
                                pc <= NOBOOT_PC;
                                core_run <= 1'b1;
                            end
                            default: begin
                                phase <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_LOADING: begin
                    if (fire && dma_word_count == 16'h0001) begin
                        phase <= ST_KERNEL;
                        kernel_running <= 1'b1;
                        core_run <= 1'b1;
                    end
                end
                ST_KERNEL, ST_NOBOOT, ST_IDLE: begin
                    phase <= phase;
                end
                default: begin
                    phase <= ST_IDLE;
                end
            endcase
        end
    end

    // control and config registers; a kernel write wins over a host one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_channel_control <= hlb_pkg::DEFAULT_DMAC;
            system_config_register <= hlb_pkg::SYSCFG_RESET;
            link_buffer_48bit <= 1'b0;
        end else begin
            if (phase == ST_SETTLE && settle == hlb_pkg::STRAP_SETTLE) begin
                case (strap_mode)
                    hlb_pkg::HLB_MODE_HOST: dma_channel_control <= hlb_pkg::HOST_DMAC_INIT;
                    hlb_pkg::HLB_MODE_LINK: begin
                        dma_channel_control <= hlb_pkg::LINK_DMAC;
                        link_buffer_48bit <= 1'b1;
                    end
                    default: dma_channel_control <= hlb_pkg::DEFAULT_DMAC;
                endcase
            end else if (kernel_dmac_wr) begin
                dma_channel_control <= kernel_dmac_data;
            end else if (host_wr_ok && s_addr == hlb_pkg::ADDR_DMAC) begin
                dma_channel_control <= s_data;
            end
            // packing width is the host's to keep consistent
            if (host_wr_ok && s_addr == hlb_pkg::ADDR_SYSCFG) begin
                system_config_register <= s_data;
            end
        end
    end

    // instruction assembly: host words lsw first, link nibbles msn first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pack_reg <= 48'h0;
            pack_cnt <= 4'h0;
            instr <= 48'h0;
            instr_valid <= 1'b0;
        end else begin
            instr_valid <= fire;
            if (word_in) begin
                if (packing_mode_field == hlb_pkg::PACKING_MODE_FIELD_NONE) begin
                    instr <= {32'h0, s_data};
                    pack_cnt <= 4'h0;
                end else if (host_fire) begin
                    instr <= {s_data, pack_reg[47:16]};
                    pack_cnt <= 4'h0;
                end else begin
                    pack_reg <= {s_data, pack_reg[47:16]};
                    pack_cnt <= pack_cnt + 4'h1;
                end
            end else if (nib_in) begin
                if (link_fire) begin
                    instr <= {pack_reg[43:0], s_ldata};
                    pack_cnt <= 4'h0;
                end else begin
                    pack_reg <= {pack_reg[43:0], s_ldata};
                    pack_cnt <= pack_cnt + 4'h1;
                end
            end
        end
    end

    // dma parameters; no external index, modify or count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_internal_index <= INDEX_BASE;
            dma_word_count <= hlb_pkg::BOOT_COUNT_INIT;
        end else begin
            if (phase == ST_SETTLE && settle == hlb_pkg::STRAP_SETTLE
                && strap_mode == hlb_pkg::HLB_MODE_NOBOOT) begin
                dma_internal_index <= hlb_pkg::DEFAULT_INDEX;
                dma_word_count <= hlb_pkg::DEFAULT_COUNT;
            end else if (fire && phase == ST_LOADING) begin
                dma_internal_index <= dma_internal_index + 20'h1;
                dma_word_count <= dma_word_count - 16'h0001;
            end
        end
    end

    // slave answers at once: boot wait states only act when we are master
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            granted <= 1'b0;
            pins.host_bus_grant_n <= 1'b1;
            pins.host_ack <= 1'b0;
            pins.link_ack <= 1'b0;
        end else begin
            granted <= !s_hbr_n && mode_valid && boot_mode == hlb_pkg::HLB_MODE_HOST;
            pins.host_bus_grant_n <= !granted;
            pins.host_ack <= granted && !bus_lock_bit;
            pins.link_ack <= phase == ST_LOADING && boot_mode == hlb_pkg::HLB_MODE_LINK;
        end
    end

endmodule

// ==== shared/hlb_pkg.sv ====
package hlb_pkg;

    // boot source picked from the three strap pins
    typedef enum logic [1:0] {
        HLB_MODE_HOST,
        HLB_MODE_LINK,
        HLB_MODE_NOBOOT,
        HLB_MODE_PROM
    } hlb_mode_e;

    // dma channel control values and field layout
    localparam logic [15:0] HOST_DMAC_INIT = 16'h02a1;
    localparam logic [15:0] KERNEL_DMAC = 16'h00a1;
    localparam logic [15:0] LINK_DMAC = 16'h00a0;
    localparam logic [15:0] DEFAULT_DMAC = 16'h0000;
    localparam int DMAC_ENABLE_BIT = 0;
    localparam int PACKING_MODE_FIELD_LSB = 8;
    localparam logic [1:0] PACKING_MODE_FIELD_NONE = 2'b00;

    // dma parameter presets and program counter values
    localparam logic [15:0] BOOT_COUNT_INIT = 16'h0100;
    localparam logic [15:0] DEFAULT_COUNT = 16'h0000;
    localparam logic [19:0] INDEX_INIT = 20'h20000;
    localparam logic [19:0] DEFAULT_INDEX = 20'h00000;
    localparam logic [23:0] HOST_PC_INIT = 24'h020004;
    localparam logic [23:0] NOBOOT_PC_INIT = 24'h400004;
    localparam logic [15:0] SYSCFG_RESET = 16'h0000;

    // host bus targets
    localparam logic [1:0] ADDR_BUFFER0 = 2'h0;
    localparam logic [1:0] ADDR_DMAC = 2'h1;
    localparam logic [1:0] ADDR_SYSCFG = 2'h2;

    // packing and strap settle counters
    localparam logic [3:0] LAST_WORD = 4'h2;
    localparam logic [3:0] LAST_NIBBLE = 4'hb;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // host timing in pclk cycles
    localparam int STROBE_CYC = 4;
    localparam int GAP_CYC = 4;
    localparam int LINK_HALF_CYC = 4;

    // host controller apb map
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_TX_LO = 12'h004;
    localparam logic [11:0] REG_TX_HI = 12'h008;
    localparam logic [11:0] REG_TX_GO = 12'h00c;
    localparam logic [11:0] REG_STATUS = 12'h010;
    localparam logic [4:0] CTRL_RESET = 5'h10;

endpackage

// ==== shared/hlb_if.sv ====
`timescale 1ns/1ps
interface hlb_if;
    // strap pins
    logic external_boot_select;
    logic link_boot_select;
    logic boot_memory_select;
    // host bus
    logic host_bus_request_n;
    logic host_chip_select_n;
    logic host_bus_grant_n;
    logic host_ack;
    logic host_write_n;
    logic [1:0] host_addr;
    logic [15:0] host_data;
    // link port
    logic link_clk;
    logic [3:0] link_data;
    logic link_ack;

    modport device (
        input external_boot_select, link_boot_select, boot_memory_select,
        input host_bus_request_n, host_chip_select_n, host_write_n, host_addr, host_data,
        output host_bus_grant_n, host_ack,
        input link_clk, link_data,
        output link_ack
    );

    modport host (
        output external_boot_select, link_boot_select, boot_memory_select,
        output host_bus_request_n, host_chip_select_n, host_write_n, host_addr, host_data,
        input host_bus_grant_n, host_ack,
        output link_clk, link_data,
        input link_ack
    );
endinterface

// ==== rtl/hlb_host.sv ====
`timescale 1ns/1ps
module hlb_host #(
    parameter int STROBE = hlb_pkg::STROBE_CYC,
    parameter int GAP = hlb_pkg::GAP_CYC,
    parameter int LINK_HALF = hlb_pkg::LINK_HALF_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins toward the device
    hlb_if.host pins
);

    typedef enum logic [2:0] {
        H_IDLE,
        H_STROBE,
        H_GAP,
        H_LHI,
        H_LLO
    } hlb_hstate_e;

    // the 8-bit timer cannot serve longer phases
    if (STROBE < 1 || STROBE > 255 || GAP < 1 || GAP > 255 || LINK_HALF < 2
        || LINK_HALF > 255) begin : g_bad_timing
        $error("hlb_host timing parameter out of range");
    end

    localparam logic [7:0] STROBE_LAST = 8'(STROBE - 1);
    localparam logic [7:0] GAP_LAST = 8'(GAP - 1);
    localparam logic [7:0] HALF_LAST = 8'(LINK_HALF - 1);

    hlb_hstate_e state;
    logic [31:0] tx_lo;
    logic [15:0] tx_hi;
    logic [47:0] tx_sh;
    logic [3:0] nib_cnt;
    logic [7:0] timer;
    logic [1:0] hbg_s;
    logic [1:0] ack_s;
    logic ready_to_write;
    logic acc, wr_acc, go, mapped;

    // grant and ack cross in from the device's clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hbg_s <= 2'b11;
            ack_s <= 2'b00;
        end else begin
            hbg_s <= {hbg_s[0], pins.host_bus_grant_n};
            ack_s <= {ack_s[0], pins.host_ack};
        end
    end

    // writes go out only once grant and ack are both seen
    assign ready_to_write = !hbg_s[1] && ack_s[1];
    assign acc = psel && penable && !pready;
    assign wr_acc = psel && penable && pready && pwrite;
    assign go = wr_acc && paddr == hlb_pkg::REG_TX_GO && state == H_IDLE
                && (pins.link_boot_select || ready_to_write);
    assign mapped = paddr == hlb_pkg::REG_CTRL || paddr == hlb_pkg::REG_TX_LO
                    || paddr == hlb_pkg::REG_TX_HI || paddr == hlb_pkg::REG_TX_GO
                    || paddr == hlb_pkg::REG_STATUS;

    // apb answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= acc;
            pslverr <= acc && !mapped;
            if (acc && !pwrite) begin
                case (paddr)
                    hlb_pkg::REG_CTRL: prdata <= {27'h0, pins.boot_memory_select,
                        pins.link_boot_select, pins.external_boot_select,
                        !pins.host_chip_select_n, !pins.host_bus_request_n};
                    hlb_pkg::REG_TX_LO: prdata <= tx_lo;
                    hlb_pkg::REG_TX_HI: prdata <= {16'h0, tx_hi};
                    hlb_pkg::REG_STATUS: prdata <= {29'h0, ack_s[1], !hbg_s[1],
                                                    state != H_IDLE};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    // control and data; straps settle before device reset ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins.host_bus_request_n <= 1'b1;
            pins.host_chip_select_n <= 1'b1;
            {pins.boot_memory_select, pins.link_boot_select,
             pins.external_boot_select} <= hlb_pkg::CTRL_RESET[4:2];
            tx_lo <= 32'h0;
            tx_hi <= 16'h0;
        end else if (wr_acc) begin
            if (paddr == hlb_pkg::REG_CTRL) begin
                pins.host_bus_request_n <= !pwdata[0];
                pins.host_chip_select_n <= !pwdata[1];
                pins.external_boot_select <= pwdata[2];
                pins.link_boot_select <= pwdata[3];
                pins.boot_memory_select <= pwdata[4];
            end
            if (paddr == hlb_pkg::REG_TX_LO) begin
                tx_lo <= pwdata;
            end
            if (paddr == hlb_pkg::REG_TX_HI) begin
                tx_hi <= pwdata[15:0];
            end
        end
    end

    // one transfer per go: host word is strobe, then gap; link instruction is twelve clocked nibbles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= H_IDLE;
            timer <= 8'h0;
            nib_cnt <= 4'h0;
            tx_sh <= 48'h0;
            pins.host_write_n <= 1'b1;
            pins.host_addr <= hlb_pkg::ADDR_BUFFER0;
            pins.host_data <= 16'h0;
            pins.link_clk <= 1'b0;
            pins.link_data <= 4'h0;
        end else begin
            timer <= timer + 8'h1;
            case (state)
                H_IDLE: begin
                    timer <= 8'h0;
                    if (go && pins.link_boot_select) begin
                        pins.link_data <= tx_hi[15:12];
                        pins.link_clk <= 1'b1;
                        tx_sh <= {tx_hi[11:0], tx_lo, 4'h0};
                        nib_cnt <= 4'h0;
                        state <= H_LHI;
                    end else if (go) begin
                        pins.host_addr <= pwdata[1:0];
                        pins.host_data <= tx_lo[15:0];
                        pins.host_write_n <= 1'b0;
                        state <= H_STROBE;
                    end
                end
                H_STROBE: begin
                    if (timer == STROBE_LAST) begin
                        pins.host_write_n <= 1'b1;
                        timer <= 8'h0;
                        state <= H_GAP;
                    end
                end
                H_GAP: begin
                    if (timer == GAP_LAST) begin
                        state <= H_IDLE;
                    end
                end
                H_LHI: begin
                    if (timer == HALF_LAST) begin
                        pins.link_clk <= 1'b0;
                        timer <= 8'h0;
                        state <= H_LLO;
                    end
                end
                H_LLO: begin
                    if (timer == HALF_LAST) begin
                        timer <= 8'h0;
                        if (nib_cnt == hlb_pkg::LAST_NIBBLE) begin
                            state <= H_IDLE;
                        end else begin
                            pins.link_data <= tx_sh[47:44];
                            tx_sh <= {tx_sh[43:0], 4'h0};
                            pins.link_clk <= 1'b1;
                            nib_cnt <= nib_cnt + 4'h1;
                            state <= H_LHI;
                        end
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end

endmodule

// ==== testbench/hlb_asserts.sv ====
`timescale 1ns/1ps
module hlb_asserts (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // straps and host bus
    input wire logic external_boot_select,
    input wire logic link_boot_select,
    input wire logic host_bus_request_n,
    input wire logic host_bus_grant_n,
    input wire logic host_ack,
    input wire logic host_write_n,
    // link port
    input wire logic link_clk,
    input wire logic [3:0] link_data,
    input wire logic link_ack
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // grant after two synchronisers
    property p_grant; $fell(host_bus_request_n) && !link_boot_select |-> ##[2:8] !host_bus_grant_n; endproperty
    a_grant: assert property (p_grant) else $error("grant late");
    property p_ack; host_ack |-> !host_bus_grant_n; endproperty
    a_ack: assert property (p_ack) else $error("ack without grant");
    property p_slave; host_bus_request_n [*8] |-> host_bus_grant_n; endproperty
    a_slave: assert property (p_slave) else $error("grant unasked");
    // strobe and spacing of host writes
    property p_strobe; $fell(host_write_n) |-> !host_write_n [*4] ##1 host_write_n; endproperty
    a_strobe: assert property (p_strobe) else $error("strobe length");
    property p_gap; $rose(host_write_n) |-> host_write_n [*4]; endproperty
    a_gap: assert property (p_gap) else $error("write gap short");
    // link clock shape, nibble hold
    property p_half; $rose(link_clk) |-> link_clk [*4] ##1 !link_clk; endproperty
    a_half: assert property (p_half) else $error("link high time");
    property p_hold; $past(link_clk) |-> $stable(link_data); endproperty
    a_hold: assert property (p_hold) else $error("link data moved");
    property p_lack; link_ack |-> link_boot_select && !external_boot_select; endproperty
    a_lack: assert property (p_lack) else $error("link ack off mode");
    c_grant: cover property (!host_bus_grant_n && host_ack);
    c_strobe: cover property ($fell(host_write_n));
    c_link: cover property ($fell(link_clk) && link_ack);
endmodule

// ==== testbench/host_and_link_boot_loader_tb.sv ====
`timescale 1ns/1ps
module host_and_link_boot_loader_tb;
    logic pclk = 0;
    logic presetn, dev_rstn, psel, penable, pwrite, pready, pslverr, kernel_dmac_wr, bus_lock_bit;
    logic mode_valid, core_run, kernel_running, link_buffer_48bit, instr_valid;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [15:0] kernel_dmac_data, dma_channel_control, system_config_register, dma_word_count;
    logic [23:0] pc;
    logic [19:0] dma_internal_index;
    logic [47:0] instr, w;
    logic [47:0] q[$];
    hlb_pkg::hlb_mode_e boot_mode;
    int n_fail, total_checks;
    hlb_if bus();
    hlb_host i_hlb_host (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .pins(bus));
    hlb_device i_hlb_device (.pclk, .presetn(dev_rstn), .pins(bus), .kernel_dmac_wr,
        .kernel_dmac_data, .bus_lock_bit, .boot_mode, .mode_valid, .core_run, .kernel_running,
        .pc, .dma_channel_control, .system_config_register, .dma_internal_index,
        .dma_word_count, .link_buffer_48bit, .instr, .instr_valid);
    hlb_asserts i_hlb_asserts (.pclk, .presetn(dev_rstn),
        .external_boot_select(bus.external_boot_select), .link_boot_select(bus.link_boot_select),
        .host_bus_request_n(bus.host_bus_request_n), .host_bus_grant_n(bus.host_bus_grant_n),
        .host_ack(bus.host_ack), .host_write_n(bus.host_write_n), .link_clk(bus.link_clk),
        .link_data(bus.link_data), .link_ack(bus.link_ack));
    initial forever #12.5 pclk = ~pclk;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string s, input logic [47:0] e, input logic [47:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // apb transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask
    // go, then poll until idle
    task automatic go(input logic [1:0] t);
        apb(1, hlb_pkg::REG_TX_GO, {30'h0, t});
        do apb(0, hlb_pkg::REG_STATUS, 0); while (rd[0] !== 1'b0);
    endtask
    task automatic hostw(input logic [15:0] v);
        apb(1, hlb_pkg::REG_TX_LO, {16'h0, v});
        go(hlb_pkg::ADDR_BUFFER0);
    endtask
    // straps move only under device reset
    task automatic dev_reset(input logic [31:0] straps);
        dev_rstn <= 0;
        apb(1, hlb_pkg::REG_CTRL, straps);
        dev_rstn <= 1;
        repeat (6) @(posedge pclk);
    endtask
    task automatic regs(input logic [23:0] p, input logic [15:0] c, input logic [19:0] x,
            input logic [15:0] n);
        chk("pc", p, pc);
        chk("dmac", c, dma_channel_control);
        chk("index", x, dma_internal_index);
        chk("count", n, dma_word_count);
    endtask
    // each instruction against the oldest note
    always @(posedge pclk)
        if (instr_valid === 1'b1)
            chk("instr", q.size() ? q.pop_front() : 'x, instr);
    initial begin
        {presetn, dev_rstn, psel, penable, pwrite, kernel_dmac_wr, bus_lock_bit} = '0;
        {paddr, pwdata, kernel_dmac_data, w} = '0;
        seed = 32'hbf01;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        dev_rstn <= 1;
        repeat (6) @(posedge pclk);
        chk("mode", hlb_pkg::HLB_MODE_HOST, boot_mode);
        regs(hlb_pkg::HOST_PC_INIT, hlb_pkg::HOST_DMAC_INIT, hlb_pkg::INDEX_INIT,
            hlb_pkg::BOOT_COUNT_INIT);
        apb(1, hlb_pkg::REG_CTRL, 32'h11);
        do apb(0, hlb_pkg::REG_STATUS, 0); while (rd[2:1] !== 2'b11);
        for (int i = 0; i < 256; i++) begin
            for (int j = 0; j < 3; j++) begin
                seed = lfsr(seed);
                w = {seed[15:0], w[47:16]};
            end
            q.push_back(w);
            for (int j = 0; j < 3; j++)
                hostw(w[16*j +: 16]);
        end
        chk("kernel", 1'b1, kernel_running);
        kernel_dmac_wr <= 1;
        kernel_dmac_data <= hlb_pkg::KERNEL_DMAC;
        @(posedge pclk);
        kernel_dmac_wr <= 0;
        @(posedge pclk);
        chk("dmac", hlb_pkg::KERNEL_DMAC, dma_channel_control);
        seed = lfsr(seed);
        q.push_back({32'h0, seed[15:0]});
        hostw(seed[15:0]);
        bus_lock_bit <= 1;
        hostw(~seed[15:0]);
        dev_reset(32'h18);
        chk("mode", hlb_pkg::HLB_MODE_LINK, boot_mode);
        chk("dmac", hlb_pkg::LINK_DMAC, dma_channel_control);
        chk("buf48", 1'b1, link_buffer_48bit);
        seed = lfsr(seed);
        q.push_back({seed[15:0], ~seed});
        apb(1, hlb_pkg::REG_TX_LO, ~seed);
        apb(1, hlb_pkg::REG_TX_HI, {16'h0, seed[15:0]});
        go(hlb_pkg::ADDR_BUFFER0);
        dev_reset(32'h0);
        chk("mode", hlb_pkg::HLB_MODE_NOBOOT, boot_mode);
        regs(hlb_pkg::NOBOOT_PC_INIT, hlb_pkg::DEFAULT_DMAC, hlb_pkg::DEFAULT_INDEX,
            hlb_pkg::DEFAULT_COUNT);
        chk("run", 1'b1, core_run);
        chk("queue", 48'h0, 48'(q.size()));
        complete_run();
    end
    initial begin
        #2000000;
        n_fail++;
        complete_run();
    end
endmodule
